// *** design/sbtc_pkg.sv ***
// Constants and carrier types for the 16-bit timer/counter core.
// Assumes an 8-bit register port with one-cycle strobes on mclk.
package sbtc_pkg;
  // Register indices on the byte-wide register port
  localparam logic [3:0] ADDR_COUNT_LO   = 4'h0;
  localparam logic [3:0] ADDR_COUNT_HI   = 4'h1;
  localparam logic [3:0] ADDR_CMPA_LO    = 4'h2;
  localparam logic [3:0] ADDR_CMPA_HI    = 4'h3;
  localparam logic [3:0] ADDR_CMPB_LO    = 4'h4;
  localparam logic [3:0] ADDR_CMPB_HI    = 4'h5;
  localparam logic [3:0] ADDR_CAPT_LO    = 4'h6;
  localparam logic [3:0] ADDR_CAPT_HI    = 4'h7;
  localparam logic [3:0] ADDR_CTRL_A     = 4'h8;
  localparam logic [3:0] ADDR_CTRL_B     = 4'h9;
  localparam logic [3:0] ADDR_FLAGS      = 4'hA;
  localparam logic [3:0] ADDR_MASK       = 4'hB;

  // Control A fields
  localparam int CA_MODE_LSB   = 0;  // wave_mode_bit0..1
  localparam int CA_OUTB_LSB   = 4;  // output action, channel B
  localparam int CA_OUTA_LSB   = 6;  // output action, channel A
  // Control B fields
  localparam int CB_CS_LSB     = 0;  // clock_select_field
  localparam int CB_MODE2      = 3;  // wave_mode_bit2
  localparam int CB_MODE3      = 4;  // wave_mode_bit3
  localparam int CB_CAPT_SRC   = 5;  // 1: comparator_output
  localparam int CB_CAPT_EDGE  = 6;  // 1: rising edge
  localparam int CB_FILTER_EN  = 7;

  // Flag and mask bit positions
  localparam int FL_OVF   = 0;
  localparam int FL_MATCH = 1;  // channel A at 1, B at 2
  localparam int FL_CAPT  = 3;
  localparam int FL_NUM   = 4;

  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT    = 16'h00FF;
  localparam logic [15:0] TOP_9BIT    = 16'h01FF;
  localparam logic [15:0] TOP_10BIT   = 16'h03FF;
  localparam int          FILTER_DEPTH = 4;
  localparam int          PRESC_W      = 10;

  // Clock select codes
  localparam logic [2:0] CS_NONE  = 3'h0;
  localparam logic [2:0] CS_DIV1  = 3'h1;
  localparam logic [2:0] CS_DIV8  = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Output actions on a match
  localparam logic [1:0] OUT_OFF    = 2'h0;
  localparam logic [1:0] OUT_TOGGLE = 2'h1;
  localparam logic [1:0] OUT_CLEAR  = 2'h2;
  localparam logic [1:0] OUT_SET    = 2'h3;

  typedef enum logic [1:0] {TOP_FIXED_MAX, TOP_FIXED_BITS, TOP_CMPA, TOP_CAPT} sbtc_top_src_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sbtc_bus_req_t;
endpackage : sbtc_pkg

// *** design/sbtc_edge_filter.sv ***
// Input conditioner: two-flop synchroniser, optional four-sample
// noise filter and edge detector with selectable polarity.
// Assumes din is asynchronous to mclk; rst_n already synchronised.
`timescale 1ns/1ns
module sbtc_edge_filter (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Control
  input  wire logic filter_en,
  input  wire logic rise_sel,
  // Signal
  input  wire logic din,
  output logic      edge_pulse
);
  logic                            sync1_reg;
  logic                            sync2_reg;
  logic [sbtc_pkg::FILTER_DEPTH-1:0] hist_reg;
  logic                            filt_reg;
  logic                            prev_reg;
  logic                            level;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= din;
      sync2_reg <= sync1_reg;
    end
  end

  // Filtered level moves only once all samples agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hist_reg <= '0;
      filt_reg <= 1'b0;
    end else begin
      hist_reg <= {hist_reg[sbtc_pkg::FILTER_DEPTH-2:0], sync2_reg};
      if (&hist_reg)
        filt_reg <= 1'b1;
      else if (~|hist_reg)
        filt_reg <= 1'b0;
    end
  end

  assign level = filter_en ? filt_reg : sync2_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg   <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      prev_reg   <= level;
      edge_pulse <= rise_sel ? (level & ~prev_reg) : (~level & prev_reg);
    end
  end
endmodule : sbtc_edge_filter

// *** design/sbtc_core.sv ***
// 16-bit timer/counter core: prescaler, counter, two compare channels
// with waveform outputs, input capture and flag/mask registers.
// Assumes a byte-wide register port on mclk; pins are asynchronous.
//
// Overview of operation
// - Count, compares, capture are 16-bit, two-byte access
// - Control registers A, B plain 8-bit
// - Four sources: overflow, match A, B, capture
// - Every request visible in the flag register
// - Each request gated by its mask bit
// - Clock select picks prescaler or pin edge
// - No clock source means no counting
// - Compares double-buffered in PWM, compared every timer tick except in a count write cycle and on the next tick
// - Compare drives PWM or frequency output
// - Match sets channel flag, may request interrupt
// - Capture copies count on pin/comparator edge
// - Selectable noise filter on capture input
// - TOP from compare A, capture or fixed
// - Compare A as PWM TOP: no A waveform
// - Compare A as PWM TOP stays double-buffered
// - Signal BOTTOM at zero, TOP at highest
// - Mode field from control A and B bits
// - Clock select zero stops; count still accessible
// - Low-byte read latches high; low write commits
// - CPU count write beats clear or count
// - Capture flag set with capture copy
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
module sbtc_core (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  // Register port
  input  wire sbtc_pkg::sbtc_bus_req_t bus_req,
  output logic [7:0]                  rdata,
  // Pins and comparator
  input  wire logic                   external_count_pin,
  input  wire logic                   capture_input_pin,
  input  wire logic                   comparator_output,
  output logic                        wave_out_a,
  output logic                        wave_oe_a,
  output logic                        wave_out_b,
  output logic                        wave_oe_b,
  // Interrupt requests and vector acknowledge
  output logic [3:0]                  irq_req,
  input  wire logic [3:0]             irq_ack
);
  logic        rst_meta_reg;
  logic        rst_n;
  logic [7:0]  ctrl_a_reg;
  logic [7:0]  ctrl_b_reg;
  logic [7:0]  temp_reg;
  logic [15:0] count_value;
  logic [15:0] capture_value;
  logic [15:0] cmp_buf [2];
  logic [15:0] cmp_act [2];
  logic [1:0]  out_act [2];
  logic [1:0]  wave_reg;
  logic [3:0]  timer_flag_register;
  logic [3:0]  timer_mask_register;
  logic [sbtc_pkg::PRESC_W-1:0] presc_reg;
  logic        count_up_reg;
  logic        block_match_reg;
  logic [3:0]  wave_mode;
  logic [2:0]  clock_select_field;
  logic        timer_tick;
  logic        ext_edge;
  logic        capt_edge;
  logic        capt_evt;
  logic        is_pwm;
  logic        dual_slope;
  logic        upd_at_bottom;
  sbtc_pkg::sbtc_top_src_t top_src;
  logic [15:0] fixed_top;
  logic [15:0] top_value;
  logic        at_top;
  logic        at_bottom;
  logic        ovf_evt;
  logic        buf_upd;
  logic [1:0]  match_evt;
  logic        wr_count;
  logic        wr_capt;
  logic [3:0]  flag_clr;
  logic [3:0]  flag_set;

  // Reset released through two flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  assign wave_mode          = {ctrl_b_reg[sbtc_pkg::CB_MODE3], ctrl_b_reg[sbtc_pkg::CB_MODE2],
                               ctrl_a_reg[sbtc_pkg::CA_MODE_LSB+1 -: 2]};
  assign clock_select_field = ctrl_b_reg[sbtc_pkg::CB_CS_LSB +: 3];
  assign out_act[0]         = ctrl_a_reg[sbtc_pkg::CA_OUTA_LSB +: 2];
  assign out_act[1]         = ctrl_a_reg[sbtc_pkg::CA_OUTB_LSB +: 2];

  // Mode decode: TOP source and count shape per waveform mode
  always_comb begin
    is_pwm        = 1'b1;
    dual_slope    = 1'b0;
    upd_at_bottom = 1'b0;
    top_src       = sbtc_pkg::TOP_FIXED_BITS;
    fixed_top     = sbtc_pkg::COUNT_MAX;
    case (wave_mode)
      4'h0, 4'hD: begin
        is_pwm  = 1'b0;
        top_src = sbtc_pkg::TOP_FIXED_MAX;
      end
      4'h4: begin
        is_pwm  = 1'b0;
        top_src = sbtc_pkg::TOP_CMPA;
      end
      4'hC: begin
        is_pwm  = 1'b0;
        top_src = sbtc_pkg::TOP_CAPT;
      end
      4'h1, 4'h5: fixed_top = sbtc_pkg::TOP_8BIT;
      4'h2, 4'h6: fixed_top = sbtc_pkg::TOP_9BIT;
      4'h3, 4'h7: fixed_top = sbtc_pkg::TOP_10BIT;
      4'h8, 4'hA, 4'hE: top_src = sbtc_pkg::TOP_CAPT;
      4'h9, 4'hB, 4'hF: top_src = sbtc_pkg::TOP_CMPA;
      default: top_src = sbtc_pkg::TOP_FIXED_MAX;
    endcase
    if (wave_mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB})
      dual_slope = 1'b1;
    if (wave_mode inside {4'h8, 4'h9})
      upd_at_bottom = 1'b1;
  end

  // TOP taken from compare A, capture or a fixed value
  always_comb begin
    case (top_src)
      sbtc_pkg::TOP_CMPA:       top_value = cmp_act[0];
      sbtc_pkg::TOP_CAPT:       top_value = capture_value;
      sbtc_pkg::TOP_FIXED_BITS: top_value = fixed_top;
      default:                  top_value = sbtc_pkg::COUNT_MAX;
    endcase
  end

  assign at_top    = (count_value == top_value);
  assign at_bottom = (count_value == 16'h0000);

  // Free-running prescaler shared by the divided selections
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      presc_reg <= '0;
    else
      presc_reg <= presc_reg + 10'h001;
  end

  sbtc_edge_filter u_ext_edge (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .filter_en  (1'b0),
    .rise_sel   (clock_select_field[0]),
    .din        (external_count_pin),
    .edge_pulse (ext_edge)
  );

  // Source and edge of the timer tick; zero selects no source
  always_comb begin
    case (clock_select_field)
      sbtc_pkg::CS_NONE:     timer_tick = 1'b0;
      sbtc_pkg::CS_DIV1:     timer_tick = 1'b1;
      sbtc_pkg::CS_DIV8:     timer_tick = &presc_reg[2:0];
      sbtc_pkg::CS_DIV64:    timer_tick = &presc_reg[5:0];
      sbtc_pkg::CS_DIV256:   timer_tick = &presc_reg[7:0];
      sbtc_pkg::CS_DIV1024:  timer_tick = &presc_reg[9:0];
      sbtc_pkg::CS_EXT_FALL, sbtc_pkg::CS_EXT_RISE: timer_tick = ext_edge;
      default:               timer_tick = 1'b0;
    endcase
  end

  // Bus decode
  assign wr_count = bus_req.wr && (bus_req.addr == sbtc_pkg::ADDR_COUNT_LO);
  // Capture is writable only while it defines TOP
  assign wr_capt  = bus_req.wr && (bus_req.addr == sbtc_pkg::ADDR_CAPT_LO) &&
                    (top_src == sbtc_pkg::TOP_CAPT);

  // Control registers, no access sequence
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_reg <= sbtc_pkg::CTRL_RESET;
      ctrl_b_reg <= sbtc_pkg::CTRL_RESET;
      timer_mask_register <= '0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == sbtc_pkg::ADDR_CTRL_A)
        ctrl_a_reg <= bus_req.wdata;
      if (bus_req.addr == sbtc_pkg::ADDR_CTRL_B)
        ctrl_b_reg <= bus_req.wdata;
      if (bus_req.addr == sbtc_pkg::ADDR_MASK)
        timer_mask_register <= bus_req.wdata[3:0];
    end
  end

  // Shared high-byte temporary: high writes land here, low reads fill it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      temp_reg <= 8'h00;
    else if (bus_req.wr && bus_req.addr inside {sbtc_pkg::ADDR_COUNT_HI, sbtc_pkg::ADDR_CMPA_HI,
                                               sbtc_pkg::ADDR_CMPB_HI, sbtc_pkg::ADDR_CAPT_HI})
      temp_reg <= bus_req.wdata;
    else if (bus_req.rd && bus_req.addr == sbtc_pkg::ADDR_COUNT_LO)
      temp_reg <= count_value[15:8];
    else if (bus_req.rd && bus_req.addr == sbtc_pkg::ADDR_CAPT_LO)
      temp_reg <= capture_value[15:8];
  end

  // Counter; a CPU write wins over count and clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_value  <= 16'h0000;
      count_up_reg <= 1'b1;
    end else if (wr_count) begin
      count_value <= {temp_reg, bus_req.wdata};
    end else if (timer_tick) begin
      if (!dual_slope) begin
        count_value <= at_top ? 16'h0000 : count_value + 16'h0001;
        count_up_reg <= 1'b1;
      end else if (count_up_reg) begin
        if (at_top) begin
          count_up_reg <= 1'b0;
          count_value  <= count_value - 16'h0001;
        end else begin
          count_value  <= count_value + 16'h0001;
        end
      end else begin
        if (at_bottom) begin
          count_up_reg <= 1'b1;
          count_value  <= count_value + 16'h0001;
        end else begin
          count_value  <= count_value - 16'h0001;
        end
      end
    end
  end

  // A count write suppresses matching on the next tick
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      block_match_reg <= 1'b0;
    else if (wr_count)
      block_match_reg <= 1'b1;
    else if (timer_tick)
      block_match_reg <= 1'b0;
  end

  // Overflow: at MAX when not PWM, at TOP single slope, at BOTTOM dual slope
  assign ovf_evt = timer_tick && !wr_count &&
                   (!is_pwm ? (count_value == sbtc_pkg::COUNT_MAX) :
                    dual_slope ? (at_bottom && !count_up_reg) : at_top);
  // Active compare values follow buffers at once, or at TOP/BOTTOM in PWM
  assign buf_upd = !is_pwm || (timer_tick && (upd_at_bottom ? at_bottom : at_top));

  // Two compare channels with their waveform outputs
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic wr_lo;
    assign wr_lo = bus_req.wr &&
                   (bus_req.addr == (ch == 0 ? sbtc_pkg::ADDR_CMPA_LO : sbtc_pkg::ADDR_CMPB_LO));

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        cmp_buf[ch] <= 16'h0000;
        cmp_act[ch] <= 16'h0000;
      end else begin
        if (wr_lo)
          cmp_buf[ch] <= {temp_reg, bus_req.wdata};
        if (buf_upd)
          cmp_act[ch] <= wr_lo ? {temp_reg, bus_req.wdata} : cmp_buf[ch];
      end
    end

    // Compared with the count on every timer tick except in a count write cycle and on the next tick
    assign match_evt[ch] = timer_tick && !block_match_reg && !wr_count &&
                           (count_value == cmp_act[ch]);

    // Waveform: toggle/clear/set on match, PWM reset at TOP or on down-match
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        wave_reg[ch] <= 1'b0;
      end else if (ch == 0 && is_pwm && top_src == sbtc_pkg::TOP_CMPA) begin
        wave_reg[ch] <= wave_reg[ch];
      end else if (!is_pwm) begin
        if (match_evt[ch]) begin
          case (out_act[ch])
            sbtc_pkg::OUT_TOGGLE: wave_reg[ch] <= ~wave_reg[ch];
            sbtc_pkg::OUT_CLEAR:  wave_reg[ch] <= 1'b0;
            sbtc_pkg::OUT_SET:    wave_reg[ch] <= 1'b1;
            default:              wave_reg[ch] <= wave_reg[ch];
          endcase
        end
      end else if (out_act[ch][1]) begin
        if (match_evt[ch])
          wave_reg[ch] <= (dual_slope && !count_up_reg) ? ~out_act[ch][0] : out_act[ch][0];
        else if (!dual_slope && timer_tick && at_top)
          wave_reg[ch] <= ~out_act[ch][0];
      end
    end
  end

  sbtc_edge_filter u_capt_edge (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .filter_en  (ctrl_b_reg[sbtc_pkg::CB_FILTER_EN]),
    .rise_sel   (ctrl_b_reg[sbtc_pkg::CB_CAPT_EDGE]),
    .din        (ctrl_b_reg[sbtc_pkg::CB_CAPT_SRC] ? comparator_output : capture_input_pin),
    .edge_pulse (capt_edge)
  );

  // Capture is off while the capture register defines TOP
  assign capt_evt = capt_edge && (top_src != sbtc_pkg::TOP_CAPT);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      capture_value <= 16'h0000;
    else if (capt_evt)
      capture_value <= count_value;
    else if (wr_capt)
      capture_value <= {temp_reg, bus_req.wdata};
  end

  // Flags: set wins over clear by one-write or vector acknowledge
  assign flag_set = {capt_evt, match_evt[1], match_evt[0], ovf_evt};
  assign flag_clr = irq_ack |
                    ((bus_req.wr && bus_req.addr == sbtc_pkg::ADDR_FLAGS) ? bus_req.wdata[3:0] : 4'h0);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      timer_flag_register <= '0;
    else
      timer_flag_register <= (timer_flag_register & ~flag_clr) | flag_set;
  end

  // Requests gated per source by the mask
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      irq_req <= 4'h0;
    else
      irq_req <= timer_flag_register & timer_mask_register;
  end

  // Pin outputs; enable follows a non-off output action
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wave_out_a <= 1'b0;
      wave_oe_a  <= 1'b0;
      wave_out_b <= 1'b0;
      wave_oe_b  <= 1'b0;
    end else begin
      wave_out_a <= wave_reg[0];
      wave_oe_a  <= (out_act[0] != sbtc_pkg::OUT_OFF);
      wave_out_b <= wave_reg[1];
      wave_oe_b  <= (out_act[1] != sbtc_pkg::OUT_OFF);
    end
  end

  // Read data one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        sbtc_pkg::ADDR_COUNT_LO: rdata <= count_value[7:0];
        sbtc_pkg::ADDR_CMPA_LO:  rdata <= cmp_buf[0][7:0];
        sbtc_pkg::ADDR_CMPA_HI:  rdata <= cmp_buf[0][15:8];
        sbtc_pkg::ADDR_CMPB_LO:  rdata <= cmp_buf[1][7:0];
        sbtc_pkg::ADDR_CMPB_HI:  rdata <= cmp_buf[1][15:8];
        sbtc_pkg::ADDR_CAPT_LO:  rdata <= capture_value[7:0];
        sbtc_pkg::ADDR_COUNT_HI, sbtc_pkg::ADDR_CAPT_HI: rdata <= temp_reg;
        sbtc_pkg::ADDR_CTRL_A:   rdata <= ctrl_a_reg;
        sbtc_pkg::ADDR_CTRL_B:   rdata <= ctrl_b_reg;
        sbtc_pkg::ADDR_FLAGS:    rdata <= {4'h0, timer_flag_register};
        sbtc_pkg::ADDR_MASK:     rdata <= {4'h0, timer_mask_register};
        default:                 rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule : sbtc_core

// *** tb/sbtc_chk.sv ***
// Port-level checker for the timer core: register port, requests, enable.
// Assumes it is bound to sbtc_core and sees only that module's ports.
`timescale 1ns/1ns
module sbtc_chk (
  // Clock and reset
  input wire logic                    mclk,
  input wire logic                    reset_n,
  // Watched ports
  input wire sbtc_pkg::sbtc_bus_req_t bus_req,
  input wire logic [7:0]              rdata,
  input wire logic                    wave_oe_a,
  input wire logic [3:0]              irq_req,
  input wire logic [3:0]              irq_ack
);
  logic [7:0] ca_reg;
  logic [7:0] cb_reg;
  logic [3:0] mk_reg;
  logic       wa;
  logic       wf;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  assign wa = bus_req.wr && bus_req.addr == sbtc_pkg::ADDR_CTRL_A;
  assign wf = bus_req.wr && bus_req.addr inside {sbtc_pkg::ADDR_FLAGS, sbtc_pkg::ADDR_MASK};
  // Shadows of what software last wrote
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ca_reg <= 8'h00;
      cb_reg <= 8'h00;
      mk_reg <= 4'h0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == sbtc_pkg::ADDR_CTRL_A) ca_reg <= bus_req.wdata;
      if (bus_req.addr == sbtc_pkg::ADDR_CTRL_B) cb_reg <= bus_req.wdata;
      if (bus_req.addr == sbtc_pkg::ADDR_MASK) mk_reg <= bus_req.wdata[3:0];
    end
  end
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
    else $error("rdata not idle");
  a_unmapped_zero: assert property ($past(bus_req.rd) && $past(bus_req.addr) >= 4'hC |-> rdata == 8'h00)
    else $error("unmapped read");
  a_ctrl_a_echo: assert property ($past(bus_req.rd) && $past(bus_req.addr) == sbtc_pkg::ADDR_CTRL_A |-> rdata == ca_reg)
    else $error("ctrl A readback");
  a_ctrl_b_echo: assert property ($past(bus_req.rd) && $past(bus_req.addr) == sbtc_pkg::ADDR_CTRL_B |-> rdata == cb_reg)
    else $error("ctrl B readback");
  a_mask_echo: assert property ($past(bus_req.rd) && $past(bus_req.addr) == sbtc_pkg::ADDR_MASK |-> rdata == {4'h0, mk_reg})
    else $error("mask readback");
  a_flag_width: assert property ($past(bus_req.rd) && $past(bus_req.addr) == sbtc_pkg::ADDR_FLAGS |-> rdata[7:4] == 4'h0)
    else $error("flag upper bits");
  a_irq_masked: assert property ((irq_req & ~mk_reg & ~$past(mk_reg)) == 4'h0)
    else $error("unmasked request");
  for (genvar i = 0; i < 4; i++) begin : g_drop
    a_irq_drop_cause: assert property ($fell(irq_req[i]) |-> $past(irq_ack[i]) || $past(irq_ack[i], 2) ||
      $past(irq_ack[i], 3) || $past(wf) || $past(wf, 2) || $past(wf, 3))
      else $error("request drop cause");
  end
  a_oe_off_a: assert property (wa && bus_req.wdata[7:6] == 2'h0 |-> ##2 !wave_oe_a)
    else $error("enable A with action off");
  a_oe_on_a: assert property (wa && bus_req.wdata[7:6] != 2'h0 |-> ##2 wave_oe_a)
    else $error("enable A missing");
  c_capture_irq: cover property (irq_req[3]);
  c_capture_read: cover property ($past(bus_req.rd) && $past(bus_req.addr) == sbtc_pkg::ADDR_CAPT_HI);
  c_wave_on: cover property (wave_oe_a);
endmodule : sbtc_chk

bind sbtc_core sbtc_chk i_sbtc_chk (.mclk(mclk), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata),
  .wave_oe_a(wave_oe_a), .irq_req(irq_req), .irq_ack(irq_ack));

// *** tb/sbtc_cpu_model.sv ***
// CPU side of the register port: 8- and 16-bit access tasks.
// Assumes every task is entered just after a rising edge of mclk.
`timescale 1ns/1ns
module sbtc_cpu_model (
  // Clock
  input wire logic                mclk,
  // Register port
  output sbtc_pkg::sbtc_bus_req_t bus_req,
  input wire logic [7:0]          rdata
);
  initial bus_req = '0;
  // Idle cycle after each strobe keeps one assignment per time step
  task automatic put(input logic [3:0] a, input logic [7:0] d, input logic w);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge mclk);
    bus_req <= '0;
  endtask : put
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    put(a, d, 1'b1);
    @(posedge mclk);
  endtask : wr8
  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    put(a, 8'h00, 1'b0);
    #1 d = rdata;
    @(posedge mclk);
  endtask : rd8
  // High byte parks in the shared temp first
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr8(a + 4'h1, d[15:8]);
    wr8(a, d[7:0]);
  endtask : wr16
  // Low byte read latches the high byte
  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    rd8(a, d[7:0]);
    rd8(a + 4'h1, d[15:8]);
  endtask : rd16
endmodule : sbtc_cpu_model

// *** tb/tb.sv ***
// Self-checking bench for sbtc_core driven through the CPU model.
// Assumes the checker is bound inside the core.
`timescale 1ns/1ns
module tb;
  logic                    mclk, reset_n, ext_pin, cap_pin, cmp_out;
  logic                    wave_out_a, wave_oe_a, wave_out_b, wave_oe_b;
  logic [3:0]              irq_ack, irq_req;
  logic [7:0]              rdata, b;
  logic [15:0]             v, got;
  logic [31:0]             seed;
  sbtc_pkg::sbtc_bus_req_t bus_req;
  int                      err_total, checked;
  logic [3:0]              ra [5] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hD};
  sbtc_core i_sbtc_core (.mclk(mclk), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata),
    .external_count_pin(ext_pin), .capture_input_pin(cap_pin), .comparator_output(cmp_out),
    .wave_out_a(wave_out_a), .wave_oe_a(wave_oe_a), .wave_out_b(wave_out_b), .wave_oe_b(wave_oe_b),
    .irq_req(irq_req), .irq_ack(irq_ack));
  sbtc_cpu_model i_sbtc_cpu_model (.mclk(mclk), .bus_req(bus_req), .rdata(rdata));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // Prescaled ticks over n clocks
  function automatic logic [15:0] ticks(input logic [2:0] cs, input int n);
    return 16'(n >> (cs == 3'h1 ? 0 : cs == 3'h2 ? 3 : 2 * cs));
  endfunction : ticks
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask : chk
  task automatic conclude;
    $display("compares %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  initial begin
    #500000;
    err_total++;
    conclude();
  end
  initial begin
    seed = 32'h00015362;
    {reset_n, ext_pin, cap_pin, cmp_out, irq_ack} = 8'h00;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (ra[i]) begin
      i_sbtc_cpu_model.rd8(ra[i], b);
      chk(b, 16'h0000, "reset value");
    end
    $display("test reset done");
    repeat (6) begin
      seed = xs(seed);
      i_sbtc_cpu_model.wr8(sbtc_pkg::ADDR_CTRL_A, seed[7:0]);
      i_sbtc_cpu_model.rd8(sbtc_pkg::ADDR_CTRL_A, b);
      chk(b, seed[7:0], "control A");
      i_sbtc_cpu_model.wr8(sbtc_pkg::ADDR_CTRL_B, {seed[15:11], 3'h0});
      i_sbtc_cpu_model.rd8(sbtc_pkg::ADDR_CTRL_B, b);
      chk(b, {seed[15:11], 3'h0}, "control B");
    end
    i_sbtc_cpu_model.wr8(sbtc_pkg::ADDR_CTRL_A, 8'hF0);
    i_sbtc_cpu_model.wr8(sbtc_pkg::ADDR_CTRL_B, 8'h00);
    $display("test control done");
    for (int a = 0; a < 6; a += 2) begin
      seed = xs(seed);
      i_sbtc_cpu_model.wr16(4'(a), seed[15:0]);
      repeat (20) @(posedge mclk);
      i_sbtc_cpu_model.rd16(4'(a), got);
      chk(got, seed[15:0], "16-bit readback");
    end
    $display("test wide access done");
    for (int cs = 1; cs < 8; cs++) begin
      i_sbtc_cpu_model.wr16(sbtc_pkg::ADDR_COUNT_LO, 16'h0000);
      i_sbtc_cpu_model.wr8(sbtc_pkg::ADDR_CTRL_B, 8'(cs));
      repeat (cs < 6 ? 256 : 20) begin
        ext_pin <= (cs > 5);
        repeat (4) @(posedge mclk);
        ext_pin <= 1'b0;
        repeat (4) @(posedge mclk);
      end
      repeat (6) @(posedge mclk);
      i_sbtc_cpu_model.wr8(sbtc_pkg::ADDR_CTRL_B, 8'h00);
      i_sbtc_cpu_model.rd16(sbtc_pkg::ADDR_COUNT_LO, got);
      v = got - ticks(3'(cs), 2056) + 16'h0002;
      if (cs < 6) chk({15'h0, v <= 16'h0004}, 16'h0001, "prescaled count");
      else chk(got, 16'h0014, "pin edge count");
    end
    $display("test clock select done");
    i_sbtc_cpu_model.wr16(sbtc_pkg::ADDR_CMPA_LO, 16'hFFF4);
    i_sbtc_cpu_model.wr16(sbtc_pkg::ADDR_CMPB_LO, 16'hFFF8);
    i_sbtc_cpu_model.wr16(sbtc_pkg::ADDR_COUNT_LO, 16'hFFF0);
    i_sbtc_cpu_model.wr8(sbtc_pkg::ADDR_CTRL_B, 8'h01);
    repeat (30) @(posedge mclk);
    i_sbtc_cpu_model.wr8(sbtc_pkg::ADDR_CTRL_B, 8'h00);
    i_sbtc_cpu_model.rd8(sbtc_pkg::ADDR_FLAGS, b);
    chk(b, 16'h0007, "overflow and matches");
    chk({wave_oe_a, wave_out_b, wave_oe_b, wave_out_a}, 16'h000F, "set on match");
    i_sbtc_cpu_model.wr8(sbtc_pkg::ADDR_FLAGS, 8'h02);
    i_sbtc_cpu_model.rd8(sbtc_pkg::ADDR_FLAGS, b);
    chk(b, 16'h0005, "write one clears");
    i_sbtc_cpu_model.wr8(sbtc_pkg::ADDR_MASK, 8'h05);
    @(posedge mclk);
    #1 chk(irq_req, 16'h0005, "masked requests");
    @(posedge mclk);
    irq_ack <= 4'h1;
    @(posedge mclk);
    irq_ack <= 4'h0;
    repeat (2) @(posedge mclk);
    #1 chk(irq_req, 16'h0004, "acknowledge clears");
    @(posedge mclk);
    i_sbtc_cpu_model.wr8(sbtc_pkg::ADDR_FLAGS, 8'h0F);
    i_sbtc_cpu_model.wr8(sbtc_pkg::ADDR_MASK, 8'h00);
    $display("test flags done");
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      v = seed[15:0];
      i_sbtc_cpu_model.wr16(sbtc_pkg::ADDR_COUNT_LO, v);
      i_sbtc_cpu_model.wr8(sbtc_pkg::ADDR_CTRL_B, {k[1], 1'b1, k[0], 5'h00});
      {cmp_out, cap_pin} <= k[0] ? 2'h2 : 2'h1;
      repeat (15) @(posedge mclk);
      i_sbtc_cpu_model.rd8(sbtc_pkg::ADDR_FLAGS, b);
      chk(b, 16'h0008, "capture flag");
      i_sbtc_cpu_model.rd16(sbtc_pkg::ADDR_CAPT_LO, got);
      chk(got, v, "captured count");
      i_sbtc_cpu_model.wr8(sbtc_pkg::ADDR_FLAGS, 8'h08);
      {cmp_out, cap_pin} <= 2'h0;
      repeat (15) @(posedge mclk);
      i_sbtc_cpu_model.rd8(sbtc_pkg::ADDR_FLAGS, b);
      chk(b, 16'h0000, "falling edge ignored");
    end
    $display("test capture done");
    conclude();
  end
endmodule : tb
